/* File: include/eeprom_slave_pkg.sv */
/*
 * Shared constants and types for the two-wire serial EEPROM slave that
 * fronts the on-chip user flash array.
 * Assumes: a 100 MHz system clock and a free-running flash timing clock.
 */
package eeprom_slave_pkg;

   // ****************************************************************
   // Array and page geometry
   // ****************************************************************
   localparam int DEPTH_1K = 128;
   localparam int DEPTH_4K = 512;
   localparam int DEPTH_8K = 1024;
   localparam int DEFAULT_DEPTH = 256;
   localparam int DEFAULT_PAGE = 8;
   localparam int BYTE_W = 8;
   localparam int FULL_ADDR_W = 10;
   localparam logic [BYTE_W-1:0] ERASED_BYTE = 8'hff;

   // ****************************************************************
   // Addressing
   // ****************************************************************
   localparam logic [3:0] DEFAULT_PREFIX = 4'ha;
   localparam logic [2:0] SEL_MASK_NONE = 3'h0;
   localparam logic [2:0] SEL_MASK_4K = 3'h1;
   localparam logic [2:0] SEL_MASK_8K = 3'h3;
   localparam int RW_BIT = 0;
   localparam int SEL_LSB = 1;
   localparam int SEL_MSB = 3;
   localparam int PREFIX_LSB = 4;
   localparam int PREFIX_MSB = 7;
   localparam int SEL_A0 = 1;
   localparam int SEL_A1 = 2;
   localparam logic [3:0] BYTE_DONE = 4'h8;
   localparam logic [3:0] CNT_ZERO = 4'h0;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int SCL_MAX_KBPS = 100;
   localparam int SYS_CLK_MHZ = 100;
   localparam int FLASH_CLK_PERIOD_NS = 12;
   localparam int PROG_TIME_NS = 100_000;
   localparam int PROG_CYCLES_DEFAULT =
      (PROG_TIME_NS + FLASH_CLK_PERIOD_NS - 1) / FLASH_CLK_PERIOD_NS;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [3:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_WORD,
      ST_WORD_ACK,
      ST_WDATA,
      ST_WDATA_ACK,
      ST_RDATA,
      ST_RDATA_ACK
   } link_state_t;

   typedef struct packed {
      logic scl;
      logic sda;
   } line_pair_t;

   typedef struct packed {
      logic bus_busy;
      logic write_busy;
      logic write_refused;
   } slave_status_t;

endpackage

/* File: verilog/flash_serial_eeprom_slave.sv */
/*
 * Two-wire serial slave that makes the user flash array look like a small
 * serial EEPROM: start/stop detection, address match, byte and page
 * writes committed after stop, sequential reads, acknowledge polling.
 * Assumes: external pull-ups resolve the open-drain lines; flash_clk runs
 * free and times the internal program cycle.
 */
//
// Behaviour
// - Bytes of eight bits, up to 100 kbit/s
// - Array depth 128, 256, 512 or 1024 bytes
// - Serial lines only pulled low or released
// - Write-protect blocks writes, whole or upper half
// - Address prefix parameter, low bits from pins
// - Start and stop seen while clock high
// - Bus busy from start until stop
// - Data changes only while clock is low
// - Ninth clock carries acknowledge, transmitter releases
// - Receiving: hold data low through acknowledge
// - Unprocessable byte: leave data high, no-acknowledge
// - No acknowledge at all while programming
// - Last address bit selects read or write
// - Select pins become byte-address bits eight, nine
// - Acknowledge only a matching slave address
// - Byte write: address, byte address, data, stop
// - Program flash only after the stop
// - Ignore new transfers while programming
// - Page writes of 8, 16 or 32 bytes
// - Master polls address until acknowledged
// - Protected: ack addresses, no-ack first data
// - Pointer advances after every byte read
`timescale 1ns/100ps
`default_nettype none

module flash_serial_eeprom_slave #(
   parameter int MEM_DEPTH = eeprom_slave_pkg::DEFAULT_DEPTH,
   parameter int PAGE_SIZE = eeprom_slave_pkg::DEFAULT_PAGE,
   parameter logic [3:0] ADDR_PREFIX = eeprom_slave_pkg::DEFAULT_PREFIX,
   parameter logic PROTECT_FULL = 1'h1,
   parameter int PROG_CYCLES = eeprom_slave_pkg::PROG_CYCLES_DEFAULT
) (
   // System clock and reset
   input wire logic clk,
   input wire logic rst,
   // Flash timing clock
   input wire logic flash_clk,
   // Serial clock line
   input wire logic scl_in,
   output var logic scl_out,
   output var logic scl_oe,
   // Serial data line
   input wire logic sda_in,
   output var logic sda_out,
   output var logic sda_oe,
   // Straps and protection
   input wire logic [2:0] device_select_pins,
   input wire logic write_protect,
   // Status
   output var eeprom_slave_pkg::slave_status_t status
);
   import eeprom_slave_pkg::*;

   localparam int ADDR_W = $clog2(MEM_DEPTH);
   localparam int PAGE_W = $clog2(PAGE_SIZE);
   localparam int PROG_W = $clog2(PROG_CYCLES + 1);
   localparam logic [2:0] SEL_MASK = (MEM_DEPTH >= DEPTH_8K) ? SEL_MASK_8K :
                                     (MEM_DEPTH >= DEPTH_4K) ? SEL_MASK_4K :
                                     SEL_MASK_NONE;
   localparam logic [PROG_W-1:0] PROG_LOAD = PROG_W'(PROG_CYCLES - 1);

   // ****************************************************************
   // Functions
   // ****************************************************************
   // Compares the received address with prefix and strapped select bits,
   // skipping select bits that carry byte-address bits instead
   function automatic logic addr_match(input logic [BYTE_W-1:0] rx,
                                       input logic [2:0] sel);
      logic pre_ok;
      logic sel_ok;
      pre_ok = (rx[PREFIX_MSB:PREFIX_LSB] == ADDR_PREFIX);
      sel_ok = (((rx[SEL_MSB:SEL_LSB] ^ sel) & ~SEL_MASK) == SEL_MASK_NONE);
      return pre_ok & sel_ok;
   endfunction

   // Next location inside the same page
   function automatic logic [ADDR_W-1:0] page_inc(input logic [ADDR_W-1:0] a);
      logic [PAGE_W-1:0] low;
      low = a[PAGE_W-1:0] + PAGE_W'(1);
      return {a[ADDR_W-1:PAGE_W], low};
   endfunction

   // ****************************************************************
   // Line synchronisers and edge detection
   // ****************************************************************
   line_pair_t line_s1;
   line_pair_t line_s2;
   line_pair_t line_prev;
   logic wp_s1;
   logic wp_s2;
   logic [2:0] sel_s1;
   logic [2:0] sel_s2;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         line_s1 <= '{scl: 1'h1, sda: 1'h1};
         line_s2 <= '{scl: 1'h1, sda: 1'h1};
         line_prev <= '{scl: 1'h1, sda: 1'h1};
         wp_s1 <= 1'h0;
         wp_s2 <= 1'h0;
         sel_s1 <= 3'h0;
         sel_s2 <= 3'h0;
      end else begin
         line_s1 <= '{scl: scl_in, sda: sda_in};
         line_s2 <= line_s1;
         line_prev <= line_s2;
         wp_s1 <= write_protect;
         wp_s2 <= wp_s1;
         sel_s1 <= device_select_pins;
         sel_s2 <= sel_s1;
      end
   end

   wire scl_rise = line_s2.scl & ~line_prev.scl;
   wire scl_fall = ~line_s2.scl & line_prev.scl;
   wire start_det = line_s2.scl & line_prev.scl & line_prev.sda & ~line_s2.sda;
   wire stop_det = line_s2.scl & line_prev.scl & ~line_prev.sda & line_s2.sda;

   // ****************************************************************
   // Link state and datapath registers
   // ****************************************************************
   link_state_t state;
   link_state_t next_state;
   logic [3:0] bit_cnt;
   logic [3:0] next_bit_cnt;
   logic [BYTE_W-1:0] rx_byte;
   logic [BYTE_W-1:0] next_rx_byte;
   logic [BYTE_W-1:0] tx_byte;
   logic [BYTE_W-1:0] next_tx_byte;
   logic next_sda_oe;
   logic [ADDR_W-1:0] ptr;
   logic [ADDR_W-1:0] next_ptr;
   logic [1:0] hi_bits;
   logic [1:0] next_hi_bits;
   logic store_data;
   logic refuse_data;

   logic [BYTE_W-1:0] mem [MEM_DEPTH];
   logic [BYTE_W-1:0] page_buf [PAGE_SIZE];
   logic [PAGE_SIZE-1:0] page_valid;
   logic [ADDR_W-1:0] page_base;
   logic req_tog;
   logic done_s1;
   logic done_s2;
   logic done_seen;
   logic done_tog;

   // ****************************************************************
   // Decoding
   // ****************************************************************
   wire [BYTE_W-1:0] rx_shift = {rx_byte[BYTE_W-2:0], line_s2.sda};
   wire byte_done = (bit_cnt == BYTE_DONE);
   wire addr_ok = addr_match(rx_byte, sel_s2);
   wire read_req = rx_byte[RW_BIT];
   wire [FULL_ADDR_W-1:0] full_addr = {hi_bits, rx_byte};
   wire [BYTE_W-1:0] rd_word = mem[ptr];
   wire protect_hit = wp_s2 & (PROTECT_FULL | ptr[ADDR_W-1]);
   wire receiving = (state == ST_ADDR) | (state == ST_WORD) | (state == ST_WDATA);
   wire commit_start = stop_det & (|page_valid) & ~status.write_busy;
   wire done_edge = done_s2 ^ done_seen;

   // ****************************************************************
   // Link state machine
   // ****************************************************************
   always_comb begin
      next_state = state;
      next_bit_cnt = bit_cnt;
      next_rx_byte = rx_byte;
      next_tx_byte = tx_byte;
      next_sda_oe = sda_oe;
      next_ptr = ptr;
      next_hi_bits = hi_bits;
      store_data = 1'h0;
      refuse_data = 1'h0;
      if (start_det) begin
         next_state = ST_ADDR;
         next_bit_cnt = CNT_ZERO;
         next_sda_oe = 1'h0;
      end else if (stop_det) begin
         next_state = ST_IDLE;
         next_sda_oe = 1'h0;
      end else if (scl_rise) begin
         if (receiving) begin
            next_rx_byte = rx_shift;
            next_bit_cnt = bit_cnt + 4'h1;
         end else if (state == ST_RDATA) begin
            next_bit_cnt = bit_cnt + 4'h1;
         end else if (state == ST_RDATA_ACK && line_s2.sda) begin
            next_state = ST_IDLE;
         end
      end else if (scl_fall) begin
         unique case (state)
            ST_IDLE: begin
               next_sda_oe = 1'h0;
            end
            ST_ADDR: begin
               if (byte_done) begin
                  if (addr_ok && !status.write_busy) begin
                     next_state = ST_ADDR_ACK;
                     next_sda_oe = 1'h1;
                     next_hi_bits = {rx_byte[SEL_A1], rx_byte[SEL_A0]};
                  end else begin
                     next_state = ST_IDLE;
                  end
               end
            end
            ST_ADDR_ACK: begin
               next_bit_cnt = CNT_ZERO;
               if (read_req) begin
                  next_state = ST_RDATA;
                  next_tx_byte = rd_word;
                  next_sda_oe = ~rd_word[BYTE_W-1];
                  next_ptr = ptr + ADDR_W'(1);
               end else begin
                  next_state = ST_WORD;
                  next_sda_oe = 1'h0;
               end
            end
            ST_WORD: begin
               if (byte_done) begin
                  next_state = ST_WORD_ACK;
                  next_sda_oe = 1'h1;
                  next_ptr = full_addr[ADDR_W-1:0];
               end
            end
            ST_WORD_ACK: begin
               next_state = ST_WDATA;
               next_bit_cnt = CNT_ZERO;
               next_sda_oe = 1'h0;
            end
            ST_WDATA: begin
               if (byte_done) begin
                  if (protect_hit) begin
                     next_state = ST_IDLE;
                     refuse_data = 1'h1;
                  end else begin
                     next_state = ST_WDATA_ACK;
                     next_sda_oe = 1'h1;
                     store_data = 1'h1;
                     next_ptr = page_inc(ptr);
                  end
               end
            end
            ST_WDATA_ACK: begin
               next_state = ST_WDATA;
               next_bit_cnt = CNT_ZERO;
               next_sda_oe = 1'h0;
            end
            ST_RDATA: begin
               if (byte_done) begin
                  next_state = ST_RDATA_ACK;
                  next_sda_oe = 1'h0;
               end else begin
                  next_tx_byte = {tx_byte[BYTE_W-2:0], 1'h0};
                  next_sda_oe = ~tx_byte[BYTE_W-2];
               end
            end
            ST_RDATA_ACK: begin
               next_state = ST_RDATA;
               next_bit_cnt = CNT_ZERO;
               next_tx_byte = rd_word;
               next_sda_oe = ~rd_word[BYTE_W-1];
               next_ptr = ptr + ADDR_W'(1);
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= ST_IDLE;
         bit_cnt <= CNT_ZERO;
         rx_byte <= 8'h00;
         tx_byte <= 8'h00;
         sda_oe <= 1'h0;
         ptr <= '0;
         hi_bits <= 2'h0;
      end else begin
         state <= next_state;
         bit_cnt <= next_bit_cnt;
         rx_byte <= next_rx_byte;
         tx_byte <= next_tx_byte;
         sda_oe <= next_sda_oe;
         ptr <= next_ptr;
         hi_bits <= next_hi_bits;
      end
   end

   // ****************************************************************
   // Open-drain drivers and status
   // ****************************************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sda_out <= 1'h0;
         scl_out <= 1'h0;
         scl_oe <= 1'h0;
         status <= '{bus_busy: 1'h0, write_busy: 1'h0, write_refused: 1'h0};
      end else begin
         sda_out <= 1'h0;
         scl_out <= 1'h0;
         scl_oe <= 1'h0;
         if (start_det) begin
            status.bus_busy <= 1'h1;
         end else if (stop_det) begin
            status.bus_busy <= 1'h0;
         end
         if (commit_start) begin
            status.write_busy <= 1'h1;
         end else if (done_edge) begin
            status.write_busy <= 1'h0;
         end
         if (refuse_data) begin
            status.write_refused <= 1'h1;
         end else if (start_det) begin
            status.write_refused <= 1'h0;
         end
      end
   end

   // ****************************************************************
   // Page buffer and flash array
   // ****************************************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         page_valid <= '0;
         page_base <= '0;
         req_tog <= 1'h0;
         for (int i = 0; i < PAGE_SIZE; i++) begin
            page_buf[i] <= ERASED_BYTE;
         end
      end else begin
         if (store_data) begin
            page_buf[ptr[PAGE_W-1:0]] <= rx_byte;
            page_valid[ptr[PAGE_W-1:0]] <= 1'h1;
            page_base <= ptr;
         end else if (done_edge) begin
            page_valid <= '0;
         end
         if (commit_start) begin
            req_tog <= ~req_tog;
         end
      end
   end

   // Programming can only clear bits, so an unerased location ends up
   // holding the AND of old and new data
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int j = 0; j < MEM_DEPTH; j++) begin
            mem[j] <= ERASED_BYTE;
         end
      end else if (done_edge) begin
         for (int i = 0; i < PAGE_SIZE; i++) begin
            if (page_valid[i]) begin
               mem[{page_base[ADDR_W-1:PAGE_W], PAGE_W'(i)}] <=
                  mem[{page_base[ADDR_W-1:PAGE_W], PAGE_W'(i)}] & page_buf[i];
            end
         end
      end
   end

   // ****************************************************************
   // Completion crossing back to the system clock
   // ****************************************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         done_s1 <= 1'h0;
         done_s2 <= 1'h0;
         done_seen <= 1'h0;
      end else begin
         done_s1 <= done_tog;
         done_s2 <= done_s1;
         done_seen <= done_s2;
      end
   end

   // ****************************************************************
   // Program cycle timer on the flash clock
   // ****************************************************************
   logic req_s1;
   logic req_s2;
   logic req_seen;
   logic prog_run;
   logic [PROG_W-1:0] prog_cnt;

   wire prog_start = req_s2 ^ req_seen;

   always_ff @(posedge flash_clk or posedge rst) begin
      if (rst) begin
         req_s1 <= 1'h0;
         req_s2 <= 1'h0;
         req_seen <= 1'h0;
         prog_run <= 1'h0;
         prog_cnt <= '0;
         done_tog <= 1'h0;
      end else begin
         req_s1 <= req_tog;
         req_s2 <= req_s1;
         req_seen <= req_s2;
         if (prog_start) begin
            prog_run <= 1'h1;
            prog_cnt <= PROG_LOAD;
         end else if (prog_run) begin
            if (prog_cnt == '0) begin
               prog_run <= 1'h0;
               done_tog <= ~done_tog;
            end else begin
               prog_cnt <= prog_cnt - PROG_W'(1);
            end
         end
      end
   end

endmodule

`default_nettype wire

/* File: tb/eeprom_slave_checker_assertions.sv */
/*
 * Checker for the serial EEPROM slave, bound to its top module ports.
 * Assumes: single clk domain for all properties; lines idle high.
 */
`timescale 1ns/100ps
`default_nettype none

module eeprom_slave_checker #(
   parameter int PROG_CYCLES = 20
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic flash_clk,
   input wire logic scl_in,
   input wire logic scl_out,
   input wire logic scl_oe,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic [2:0] device_select_pins,
   input wire logic write_protect,
   input wire eeprom_slave_pkg::slave_status_t status
);
   import eeprom_slave_pkg::*;
   localparam int PROG_CLK = PROG_CYCLES * FLASH_CLK_PERIOD_NS / 10;
   logic [15:0] busy_cnt;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // Length of the program interval in system clocks
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         busy_cnt <= 16'h0000;
      end else if (status.write_busy) begin
         busy_cnt <= busy_cnt + 16'h0001;
      end else begin
         busy_cnt <= 16'h0000;
      end
   end

   property p_open_drain;
      !scl_oe && !scl_out && !sda_out;
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("line driven high");
   property p_start_busy;
      $fell(sda_in) && scl_in |-> ##[1:6] status.bus_busy;
   endproperty
   a_start_busy: assert property (p_start_busy) else $error("start missed");
   property p_stop_free;
      $rose(sda_in) && scl_in |-> ##[1:6] !status.bus_busy;
   endproperty
   a_stop_free: assert property (p_stop_free) else $error("stop missed");
   property p_sda_change_low;
      $changed(sda_oe) |-> !scl_in;
   endproperty
   a_sda_change_low: assert property (p_sda_change_low) else $error("sda moved, scl high");
   property p_ack_hold;
      $rose(scl_in) && sda_oe |-> sda_oe [*8];
   endproperty
   a_ack_hold: assert property (p_ack_hold) else $error("ack dropped early");
   property p_no_ack_prog;
      status.write_busy |-> !sda_oe;
   endproperty
   a_no_ack_prog: assert property (p_no_ack_prog) else $error("ack while programming");
   property p_commit_after_stop;
      $rose(status.write_busy) |-> ##[0:4] (!status.bus_busy && scl_in && sda_in);
   endproperty
   a_commit_after_stop: assert property (p_commit_after_stop) else $error("early commit");
   property p_prog_len;
      $fell(status.write_busy) |-> busy_cnt >= PROG_CLK - 4 && busy_cnt <= PROG_CLK + 16;
   endproperty
   a_prog_len: assert property (p_prog_len) else $error("program time wrong");
   property p_refused_idle;
      status.write_refused |-> !status.write_busy;
   endproperty
   a_refused_idle: assert property (p_refused_idle) else $error("refused data written");

   c_commit: cover property ($rose(status.write_busy));
   c_refused: cover property ($rose(status.write_refused));
   c_ack: cover property ($rose(sda_oe) && status.bus_busy);
endmodule

bind flash_serial_eeprom_slave eeprom_slave_checker #(.PROG_CYCLES(PROG_CYCLES)) chk_u (
   .clk(clk), .rst(rst), .flash_clk(flash_clk), .scl_in(scl_in), .scl_out(scl_out),
   .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
   .device_select_pins(device_select_pins), .write_protect(write_protect), .status(status)
);
`default_nettype wire

/* File: tb/i2c_master_model.sv */
/*
 * Behavioural two-wire bus master; each step is QTR clocks plus 1 ns.
 * Assumes: the bench resolves the wired-AND lines with a pull-up.
 */
`timescale 1ns/100ps
`default_nettype none

module i2c_master_model #(
   parameter int QTR = 40
) (
   // Step timing and resolved data line
   input wire logic clk,
   input wire logic sda,
   // Releases, high lets the pull-up win
   output var logic scl_rel,
   output var logic sda_rel
);
   initial begin
      scl_rel = 1'b1;
      sda_rel = 1'b1;
   end
   task automatic step();
      repeat (QTR) @(posedge clk);
      #1;
   endtask
   // Only begun from a free bus or as a repeated start
   task automatic start_c();
      sda_rel = 1'b1;
      step();
      scl_rel = 1'b1;
      step();
      sda_rel = 1'b0;
      step();
      scl_rel = 1'b0;
      step();
   endtask
   task automatic stop_c();
      sda_rel = 1'b0;
      step();
      scl_rel = 1'b1;
      step();
      sda_rel = 1'b1;
      step();
   endtask
   // Data set while clock low, sampled mid high
   task automatic bit_c(input logic v, output logic s);
      sda_rel = v;
      step();
      scl_rel = 1'b1;
      step();
      s = sda;
      step();
      scl_rel = 1'b0;
      step();
   endtask
   task automatic put_byte(input logic [7:0] b, output logic nak);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_c(b[i], s);
      end
      bit_c(1'b1, nak);
   endtask
   task automatic get_byte(input logic give_ack, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_c(1'b1, b[i]);
      end
      bit_c(!give_ack, s);
   endtask
endmodule
`default_nettype wire

/* File: tb/flash_serial_eeprom_slave_tb_top.sv */
/*
 * Self-checking bench: byte, page and protected writes, polling, reads.
 * Assumes: 512-byte array, upper-half protect, select straps 3'b010;
 * a second 1024-byte slave with full protect answers prefix 4'hb.
 */
`timescale 1ns/100ps
`default_nettype none

module flash_serial_eeprom_slave_tb_top;
   import eeprom_slave_pkg::*;
   localparam int PROG = 2000;
   logic clk, rst, flash_clk, wp, scl_oe, scl_out, sda_oe, sda_out, scl_rel, sda_rel, nak;
   logic sda_oe2;
   logic [2:0] sel_pins;
   logic [7:0] rb;
   slave_status_t status;
   slave_status_t status2;
   int err_total = 0;
   int checks = 0;
   int tries;
   wire logic scl_w = scl_rel & ~scl_oe;
   wire logic sda_w = sda_rel & ~sda_oe & ~sda_oe2;

   flash_serial_eeprom_slave #(.MEM_DEPTH(DEPTH_4K), .PAGE_SIZE(DEFAULT_PAGE),
      .ADDR_PREFIX(DEFAULT_PREFIX), .PROTECT_FULL(1'h0), .PROG_CYCLES(PROG)) dut_u (
      .clk(clk), .rst(rst), .flash_clk(flash_clk), .scl_in(scl_w), .scl_out(scl_out),
      .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
      .device_select_pins(sel_pins), .write_protect(wp), .status(status));
   // Whole-array protect and the 1024-byte select decoding
   flash_serial_eeprom_slave #(.MEM_DEPTH(DEPTH_8K), .PAGE_SIZE(DEFAULT_PAGE),
      .ADDR_PREFIX(4'hb), .PROTECT_FULL(1'h1), .PROG_CYCLES(PROG)) prot_u (
      .clk(clk), .rst(rst), .flash_clk(flash_clk), .scl_in(scl_w), .scl_out(),
      .scl_oe(), .sda_in(sda_w), .sda_out(), .sda_oe(sda_oe2),
      .device_select_pins(sel_pins), .write_protect(wp), .status(status2));
   i2c_master_model #(.QTR(30)) mst_u (.clk(clk), .sda(sda_w), .scl_rel(scl_rel),
      .sda_rel(sda_rel));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      flash_clk = 1'b0;
      #3;
      forever #6 flash_clk = ~flash_clk;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   function automatic logic [7:0] sa(input logic [3:0] pre, input logic a1, input logic a8,
                                     input logic rw);
      return {pre, 1'b0, a1, a8, rw};
   endfunction
   task automatic head(input logic [9:0] a);
      mst_u.start_c();
      mst_u.put_byte(sa(DEFAULT_PREFIX, 1'b1, a[8], 1'b0), nak);
      check({7'h00, nak}, 8'h00);
      mst_u.put_byte(a[7:0], nak);
      check({7'h00, nak}, 8'h00);
   endtask
   task automatic wr(input logic [9:0] a, input logic [7:0] d0, input logic [7:0] inc,
                     input int n, input logic exp_nak);
      head(a);
      for (int k = 0; k < n; k++) begin
         mst_u.put_byte(d0 + 8'(k) * inc, nak);
         check({7'h00, nak}, {7'h00, exp_nak});
      end
      mst_u.stop_c();
   endtask
   task automatic rd(input logic [9:0] a, input int n, input logic [7:0] d0,
                     input logic [7:0] inc);
      head(a);
      mst_u.start_c();
      mst_u.put_byte(sa(DEFAULT_PREFIX, 1'b1, a[8], 1'b1), nak);
      check({7'h00, nak}, 8'h00);
      for (int k = 0; k < n; k++) begin
         mst_u.get_byte(k < n - 1, rb);
         check(rb, d0 + 8'(k) * inc);
      end
      mst_u.stop_c();
   endtask
   // Leaves the bus held after the ack, so the next start is a repeated one
   task automatic poll();
      tries = 0;
      nak = 1'b1;
      while (nak === 1'b1 && tries < 40) begin
         mst_u.start_c();
         mst_u.put_byte(sa(DEFAULT_PREFIX, 1'b1, 1'b0, 1'b0), nak);
         if (nak !== 1'b0) begin
            mst_u.stop_c();
         end
         tries++;
      end
      check({7'h00, nak}, 8'h00);
      check({7'h00, tries > 1}, 8'h01);
   endtask
   task automatic give_verdict();
      $display("checks=%0d mismatches=%0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      #1000000;
      err_total++;
      $display("watchdog expired");
      give_verdict();
   end

   initial begin
      rst = 1'b1;
      wp = 1'b0;
      sel_pins = 3'b010;
      repeat (3) @(posedge clk);
      #1 rst = 1'b0;
      repeat (5) @(posedge clk);
      check({5'h00, status}, 8'h00);
      rd(10'h005, 2, ERASED_BYTE, 8'h00);
      $display("erased read done");
      wr(10'h012, 8'h5a, 8'h00, 1, 1'b0);
      check({7'h00, status.write_busy}, 8'h01);
      poll();
      rd(10'h012, 2, 8'h5a, 8'ha5);
      $display("byte write done");
      wr(10'h040, 8'h11, 8'h11, 8, 1'b0);
      poll();
      rd(10'h040, 8, 8'h11, 8'h11);
      $display("page write done");
      wr(10'h130, 8'h3c, 8'h00, 1, 1'b0);
      poll();
      rd(10'h130, 1, 8'h3c, 8'h00);
      rd(10'h030, 1, ERASED_BYTE, 8'h00);
      $display("high address done");
      for (int i = 0; i < 2; i++) begin
         mst_u.start_c();
         mst_u.put_byte(sa(i == 0 ? 4'hc : DEFAULT_PREFIX, 1'b0, 1'b0, 1'b0), nak);
         check({7'h00, nak}, 8'h01);
         mst_u.stop_c();
      end
      $display("address mismatch done");
      @(posedge clk);
      #1 wp = 1'b1;
      wr(10'h180, 8'h00, 8'h00, 1, 1'b1);
      check({5'h00, status}, 8'h01);
      mst_u.start_c();
      mst_u.put_byte(sa(4'hb, 1'b1, 1'b0, 1'b0), nak);
      check({7'h00, nak}, 8'h00);
      mst_u.put_byte(8'h10, nak);
      check({7'h00, nak}, 8'h00);
      mst_u.put_byte(8'h00, nak);
      check({7'h00, nak}, 8'h01);
      mst_u.stop_c();
      check({5'h00, status2}, 8'h01);
      rd(10'h180, 1, ERASED_BYTE, 8'h00);
      wr(10'h050, 8'h77, 8'h00, 1, 1'b0);
      poll();
      @(posedge clk);
      #1 wp = 1'b0;
      rd(10'h050, 1, 8'h77, 8'h00);
      $display("write protect done");
      give_verdict();
   end
endmodule
`default_nettype wire
